// >>> hdl/ddcis_regs.svh
// register indices, field positions, reset values and bus codes for the downconverter
`ifndef DDCIS_REGS_SVH
`define DDCIS_REGS_SVH
`define DDCIS_CTRL_IDX 14'h0350
`define DDCIS_INSEL_IDX 14'h0351
`define DDCIS_CTRL_RESET 8'h00
`define DDCIS_INSEL_RESET 8'h00
`define DDCIS_INSEL_WMASK 8'hf5
`define DDCIS_MIXER_BIT 7
`define DDCIS_GAIN_BIT 6
`define DDCIS_IFMODE_HI 5
`define DDCIS_IFMODE_LO 4
`define DDCIS_C2R_BIT 3
`define DDCIS_DEC_HI 2
`define DDCIS_DEC_LO 0
`define DDCIS_EXT_HI 7
`define DDCIS_EXT_LO 4
`define DDCIS_QSEL_BIT 2
`define DDCIS_ISEL_BIT 0
`define DDCIS_DEC_EXTENDED 3'h7
`define DDCIS_RESP_OKAY 2'h0
`define DDCIS_RESP_SLVERR 2'h2
`endif

// >>> hdl/ddcis_pkg.sv
// types shared by the downconverter decimation and input select block
package ddcis_pkg;
  typedef struct packed {
    logic fifth_band_stage;
    logic third_band_stage;
    logic half_band_stage_four;
    logic half_band_stage_three;
    logic half_band_stage_two;
    logic half_band_stage_one;
  } ddcis_stages_t;

  typedef struct packed {
    ddcis_stages_t stages;
    logic [5:0] ratio;
  } ddcis_chain_t;

  typedef struct packed {
    logic [15:0] i;
    logic [15:0] q;
  } ddcis_iq_t;

  typedef enum logic [1:0] {
    DDCIS_WR_IDLE,
    DDCIS_WR_HAVE_ADDR,
    DDCIS_WR_HAVE_DATA,
    DDCIS_WR_RESP
  } ddcis_wr_state_t;
endpackage

// >>> hdl/ddcis_decim_counter.sv
// sample counter that picks one input sample out of every ratio
`timescale 1ns/100ps
module ddcis_decim_counter (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic sample_valid_in,
  input wire logic [5:0] ratio_in,
  output logic tick_out
);
  logic [5:0] count;
  logic [5:0] next_count;
  logic last;

  // a ratio lowered mid-count still ends at once, never wraps past 63
  assign last = (count + 6'h01) >= ratio_in;
  assign tick_out = sample_valid_in && last;

  always_comb begin
    next_count = count;
    if (sample_valid_in) begin
      next_count = last ? 6'h00 : count + 6'h01;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count <= 6'h00;
    end else begin
      count <= next_count;
    end
  end
endmodule

// >>> hdl/ddcis_top.sv
// downconverter decimation chain, real conversion and input routing with axi4-lite registers
// Behaviour
// - complex mode: in-phase and quadrature both valid
// - real mode: in-phase only, extra quarter-rate mix
// - code 000: stages one, two; 2/4
// - code 001: stages one to three; 4/8
// - code 010: stages one to four; 8/16
// - code 011: stage one only; 1/2
// - code 100: stage one plus third-band; 3/6
// - code 101: one, two, third-band; 6/12
// - code 110: one to three, third-band; 12/24
// - code 111 defers to extended field
// - extended field ignored unless code 111
// - extended 0: third-band, four to one; 24/48
// - extended 10: fifth-band, one; 5/10
// - extended 11: fifth-band, two, one; 10/20
// - extended 100: fifth-band, three to one; 20/40
//
// The implementer's own choice: the AXI4-Lite register port.
`timescale 1ns/100ps
`include "ddcis_regs.svh"
module ddcis_top (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic [15:0] s_axi_awaddr_in,
  input wire logic s_axi_awvalid_in,
  output logic s_axi_awready_out,
  input wire logic [31:0] s_axi_wdata_in,
  input wire logic [3:0] s_axi_wstrb_in,
  input wire logic s_axi_wvalid_in,
  output logic s_axi_wready_out,
  output logic [1:0] s_axi_bresp_out,
  output logic s_axi_bvalid_out,
  input wire logic s_axi_bready_in,
  input wire logic [15:0] s_axi_araddr_in,
  input wire logic s_axi_arvalid_in,
  output logic s_axi_arready_out,
  output logic [31:0] s_axi_rdata_out,
  output logic [1:0] s_axi_rresp_out,
  output logic s_axi_rvalid_out,
  input wire logic s_axi_rready_in,
  input wire logic [15:0] chan_a_in,
  input wire logic [15:0] chan_b_in,
  input wire logic sample_valid_in,
  output ddcis_pkg::ddcis_iq_t iq_out,
  output logic i_valid_out,
  output logic q_valid_out,
  output ddcis_pkg::ddcis_stages_t stage_enable_out,
  output logic mixer_type_select_out,
  output logic gain_select_out,
  output logic [1:0] if_mode_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (sys_rst_in);

  function automatic logic addr_hit(input logic [15:0] addr, input logic [13:0] idx);
    addr_hit = addr == {idx, 2'b00};
  endfunction

  function automatic ddcis_pkg::ddcis_chain_t decode_chain(input logic [2:0] dec,
                                                          input logic [3:0] ext);
    ddcis_pkg::ddcis_chain_t c;
    c = '0;
    case (dec)
      3'h0: c = '{stages: 6'b000011, ratio: 6'd4};
      3'h1: c = '{stages: 6'b000111, ratio: 6'd8};
      3'h2: c = '{stages: 6'b001111, ratio: 6'd16};
      3'h3: c = '{stages: 6'b000001, ratio: 6'd2};
      3'h4: c = '{stages: 6'b010001, ratio: 6'd6};
      3'h5: c = '{stages: 6'b010011, ratio: 6'd12};
      3'h6: c = '{stages: 6'b010111, ratio: 6'd24};
      default: begin
        case (ext)
          4'h0: c = '{stages: 6'b011111, ratio: 6'd48};
          4'h2: c = '{stages: 6'b100001, ratio: 6'd10};
          4'h3: c = '{stages: 6'b100011, ratio: 6'd20};
          4'h4: c = '{stages: 6'b100111, ratio: 6'd40};
          // undefined codes fall back to stage one so the output never stalls
          default: c = '{stages: 6'b000001, ratio: 6'd2};
        endcase
      end
    endcase
    decode_chain = c;
  endfunction

  ddcis_pkg::ddcis_wr_state_t wr_state;
  ddcis_pkg::ddcis_wr_state_t next_wr_state;
  logic [15:0] aw_addr;
  logic [15:0] next_aw_addr;
  logic [31:0] w_data;
  logic [31:0] next_w_data;
  logic [3:0] w_strb;
  logic [3:0] next_w_strb;
  logic [1:0] bresp;
  logic [1:0] next_bresp;
  logic [7:0] ctrl;
  logic [7:0] next_ctrl;
  logic [7:0] insel;
  logic [7:0] next_insel;
  logic [15:0] eff_addr;
  logic [31:0] eff_data;
  logic [3:0] eff_strb;
  logic do_write;

  assign s_axi_awready_out = (wr_state == ddcis_pkg::DDCIS_WR_IDLE) ||
                             (wr_state == ddcis_pkg::DDCIS_WR_HAVE_DATA);
  assign s_axi_wready_out = (wr_state == ddcis_pkg::DDCIS_WR_IDLE) ||
                            (wr_state == ddcis_pkg::DDCIS_WR_HAVE_ADDR);
  assign s_axi_bvalid_out = wr_state == ddcis_pkg::DDCIS_WR_RESP;
  assign s_axi_bresp_out = bresp;

  always_comb begin
    next_wr_state = wr_state;
    next_aw_addr = aw_addr;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bresp = bresp;
    next_ctrl = ctrl;
    next_insel = insel;
    do_write = 1'b0;
    eff_addr = (wr_state == ddcis_pkg::DDCIS_WR_HAVE_ADDR) ? aw_addr : s_axi_awaddr_in;
    eff_data = (wr_state == ddcis_pkg::DDCIS_WR_HAVE_DATA) ? w_data : s_axi_wdata_in;
    eff_strb = (wr_state == ddcis_pkg::DDCIS_WR_HAVE_DATA) ? w_strb : s_axi_wstrb_in;
    case (wr_state)
      ddcis_pkg::DDCIS_WR_IDLE: begin
        if (s_axi_awvalid_in && s_axi_wvalid_in) begin
          do_write = 1'b1;
        end else if (s_axi_awvalid_in) begin
          next_aw_addr = s_axi_awaddr_in;
          next_wr_state = ddcis_pkg::DDCIS_WR_HAVE_ADDR;
        end else if (s_axi_wvalid_in) begin
          next_w_data = s_axi_wdata_in;
          next_w_strb = s_axi_wstrb_in;
          next_wr_state = ddcis_pkg::DDCIS_WR_HAVE_DATA;
        end
      end
      ddcis_pkg::DDCIS_WR_HAVE_ADDR: begin
        do_write = s_axi_wvalid_in;
      end
      ddcis_pkg::DDCIS_WR_HAVE_DATA: begin
        do_write = s_axi_awvalid_in;
      end
      ddcis_pkg::DDCIS_WR_RESP: begin
        if (s_axi_bready_in) begin
          next_wr_state = ddcis_pkg::DDCIS_WR_IDLE;
        end
      end
      default: begin
        next_wr_state = ddcis_pkg::DDCIS_WR_IDLE;
      end
    endcase
    if (do_write) begin
      next_wr_state = ddcis_pkg::DDCIS_WR_RESP;
      next_bresp = `DDCIS_RESP_OKAY;
      if (addr_hit(eff_addr, `DDCIS_CTRL_IDX)) begin
        if (eff_strb[0]) begin
          next_ctrl = eff_data[7:0];
        end
      end else if (addr_hit(eff_addr, `DDCIS_INSEL_IDX)) begin
        if (eff_strb[0]) begin
          next_insel = eff_data[7:0] & `DDCIS_INSEL_WMASK;
        end
      end else begin
        next_bresp = `DDCIS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      wr_state <= ddcis_pkg::DDCIS_WR_IDLE;
      aw_addr <= 16'h0000;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      bresp <= `DDCIS_RESP_OKAY;
      ctrl <= `DDCIS_CTRL_RESET;
      insel <= `DDCIS_INSEL_RESET;
    end else begin
      wr_state <= next_wr_state;
      aw_addr <= next_aw_addr;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      bresp <= next_bresp;
      ctrl <= next_ctrl;
      insel <= next_insel;
    end
  end

  logic rvalid;
  logic next_rvalid;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [1:0] rresp;
  logic [1:0] next_rresp;

  assign s_axi_arready_out = !rvalid;
  assign s_axi_rvalid_out = rvalid;
  assign s_axi_rdata_out = rdata;
  assign s_axi_rresp_out = rresp;

  always_comb begin
    next_rvalid = rvalid;
    next_rdata = rdata;
    next_rresp = rresp;
    if (rvalid && s_axi_rready_in) begin
      next_rvalid = 1'b0;
    end
    if (!rvalid && s_axi_arvalid_in) begin
      next_rvalid = 1'b1;
      next_rresp = `DDCIS_RESP_OKAY;
      next_rdata = 32'h00000000;
      if (addr_hit(s_axi_araddr_in, `DDCIS_CTRL_IDX)) begin
        next_rdata = {24'h000000, ctrl};
      end else if (addr_hit(s_axi_araddr_in, `DDCIS_INSEL_IDX)) begin
        next_rdata = {24'h000000, insel};
      end else begin
        next_rresp = `DDCIS_RESP_SLVERR;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      rvalid <= 1'b0;
      rdata <= 32'h00000000;
      rresp <= `DDCIS_RESP_OKAY;
    end else begin
      rvalid <= next_rvalid;
      rdata <= next_rdata;
      rresp <= next_rresp;
    end
  end

  logic c2r;
  ddcis_pkg::ddcis_chain_t chain;
  logic [5:0] out_ratio;
  logic tick;
  ddcis_pkg::ddcis_iq_t routed;
  ddcis_pkg::ddcis_iq_t next_iq;
  logic next_i_valid;
  logic next_q_valid;
  logic [1:0] mix_phase;
  logic [1:0] next_mix_phase;

  assign c2r = ctrl[`DDCIS_C2R_BIT];
  assign chain = decode_chain(ctrl[`DDCIS_DEC_HI:`DDCIS_DEC_LO],
                              insel[`DDCIS_EXT_HI:`DDCIS_EXT_LO]);
  // real output runs at twice the complex rate of the same chain
  assign out_ratio = c2r ? (chain.ratio >> 1) : chain.ratio;
  assign stage_enable_out = chain.stages;
  assign mixer_type_select_out = ctrl[`DDCIS_MIXER_BIT];
  assign gain_select_out = ctrl[`DDCIS_GAIN_BIT];
  assign if_mode_out = ctrl[`DDCIS_IFMODE_HI:`DDCIS_IFMODE_LO];
  // a real mixer with split selects is left to software to avoid
  assign routed = {insel[`DDCIS_ISEL_BIT] ? chan_b_in : chan_a_in,
                   insel[`DDCIS_QSEL_BIT] ? chan_b_in : chan_a_in};

  ddcis_decim_counter u_decim (
    .core_clk_in(core_clk_in),
    .sys_rst_in(sys_rst_in),
    .sample_valid_in(sample_valid_in),
    .ratio_in(out_ratio),
    .tick_out(tick)
  );

  always_comb begin
    next_iq = iq_out;
    next_i_valid = tick;
    next_q_valid = tick && !c2r;
    next_mix_phase = mix_phase;
    if (tick) begin
      if (c2r) begin
        // quarter-rate mix i*cos - q*sin; full-scale negative wraps
        case (mix_phase)
          2'h0: next_iq.i = routed.i;
          2'h1: next_iq.i = 16'h0000 - routed.q;
          2'h2: next_iq.i = 16'h0000 - routed.i;
          default: next_iq.i = routed.q;
        endcase
        next_iq.q = 16'h0000;
        next_mix_phase = mix_phase + 2'h1;
      end else begin
        next_iq = routed;
        next_mix_phase = 2'h0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      iq_out <= '0;
      i_valid_out <= 1'b0;
      q_valid_out <= 1'b0;
      mix_phase <= 2'h0;
    end else begin
      iq_out <= next_iq;
      i_valid_out <= next_i_valid;
      q_valid_out <= next_q_valid;
      mix_phase <= next_mix_phase;
    end
  end

  sequence complex_tick_s;
    tick && !c2r;
  endsequence
  sequence both_valid_s;
    i_valid_out && q_valid_out;
  endsequence

  complex_both_a: assert property (complex_tick_s |=> both_valid_s)
    else $error("complex sample lost a lane");
  real_only_a: assert property ((tick && c2r) |=> (i_valid_out && !q_valid_out))
    else $error("real mode drove quadrature");
  dec_zero_a: assert property ((ctrl[2:0] == 3'h0) |-> (chain.ratio == 6'd4 &&
                               chain.stages == 6'b000011))
    else $error("code 000 chain wrong");
  dec_two_a: assert property ((ctrl[2:0] == 3'h2 && c2r) |-> out_ratio == 6'd8)
    else $error("code 010 real ratio wrong");
  dec_three_a: assert property ((ctrl[2:0] == 3'h3 && c2r) |-> out_ratio == 6'd1)
    else $error("code 011 real ratio wrong");
  dec_six_a: assert property ((ctrl[2:0] == 3'h6) |-> chain.stages.third_band_stage)
    else $error("code 110 lacks third band");
  ext_ignored_a: assert property ((ctrl[2:0] != 3'h7) |-> !chain.stages.fifth_band_stage)
    else $error("extended field leaked");
  ext_zero_a: assert property ((ctrl[2:0] == 3'h7 && insel[7:4] == 4'h0) |->
                               chain.ratio == 6'd48)
    else $error("extended 0 ratio wrong");
  ext_four_a: assert property ((ctrl[2:0] == 3'h7 && insel[7:4] == 4'h4 && c2r) |->
                               out_ratio == 6'd20)
    else $error("extended 100 real ratio wrong");
  q_route_a: assert property (complex_tick_s |=> iq_out.q ==
                              ($past(insel[2]) ? $past(chan_b_in) : $past(chan_a_in)))
    else $error("quadrature routed from wrong channel");
  i_route_a: assert property (complex_tick_s |=> iq_out.i ==
                              ($past(insel[0]) ? $past(chan_b_in) : $past(chan_a_in)))
    else $error("in-phase routed from wrong channel");
  reserved_zero_a: assert property ((rvalid && rresp == 2'h0) |-> rdata[31:8] == 24'h0 &&
                                    !insel[3] && !insel[1])
    else $error("reserved bits not zero");
endmodule

// >>> bench/ddcis_conv_model.sv
// converter channel pair model feeding samples to the downconverter
`timescale 1ns/100ps
module ddcis_conv_model (
  input wire logic core_clk_in,
  input wire logic sys_rst_in,
  input wire logic run_in,
  input wire logic slow_in,
  output logic [15:0] chan_a_out,
  output logic [15:0] chan_b_out,
  output logic sample_valid_out
);
  logic [15:0] count;
  logic phase;
  // channel b runs 0x1000 above channel a so routing shows in the outputs
  always_ff @(posedge core_clk_in) begin
    if (sys_rst_in) begin
      count <= 16'h0000;
      phase <= 1'b0;
      sample_valid_out <= 1'b0;
      chan_a_out <= 16'h0000;
      chan_b_out <= 16'h0000;
    end else begin
      phase <= ~phase;
      if (run_in && (!slow_in || phase)) begin
        sample_valid_out <= 1'b1;
        chan_a_out <= 16'h1000 + count;
        chan_b_out <= 16'h2000 + count;
        count <= count + 16'h0001;
      end else begin
        // stale data is inverted so a missing valid check cannot pass by luck
        sample_valid_out <= 1'b0;
        chan_a_out <= ~chan_a_out;
        chan_b_out <= ~chan_b_out;
      end
    end
  end
endmodule

// >>> bench/tb_top.sv
// self-checking bench for the downconverter decimation and input select block
`timescale 1ns/100ps
`include "ddcis_regs.svh"
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin err_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic run = 1'b0;
  logic slow = 1'b0;
  logic [15:0] awaddr = 16'h0000;
  logic [15:0] araddr = 16'h0000;
  logic [31:0] wdata = 32'h00000000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic [15:0] chan_a;
  logic [15:0] chan_b;
  logic sv;
  logic awready, wready, bvalid, arready, rvalid, i_valid, q_valid, mix, gain;
  logic [1:0] bresp;
  logic [1:0] rresp;
  logic [1:0] ifm;
  logic [31:0] rdata;
  ddcis_pkg::ddcis_iq_t iq;
  ddcis_pkg::ddcis_stages_t stg;
  int err_count = 0;
  int comparisons = 0;
  int p;
  localparam logic [15:0] ctrl_addr = {`DDCIS_CTRL_IDX, 2'b00};
  localparam logic [15:0] insel_addr = {`DDCIS_INSEL_IDX, 2'b00};
  // code, extended code, stage mask, complex ratio
  localparam logic [23:0] tbl [12] = '{24'h000304, 24'h100708, 24'h200f10, 24'h300102,
    24'h401106, 24'h50130c, 24'h601718, 24'h701f30, 24'h72210a, 24'h732314,
    24'h742728, 24'h340102};

  always #5 clk = ~clk;

  ddcis_conv_model conv_u (.core_clk_in(clk), .sys_rst_in(rst), .run_in(run),
    .slow_in(slow), .chan_a_out(chan_a), .chan_b_out(chan_b), .sample_valid_out(sv));

  ddcis_top dut_u (.core_clk_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr),
    .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
    .s_axi_wstrb_in(4'h1), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
    .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
    .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
    .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
    .s_axi_rready_in(rready), .chan_a_in(chan_a), .chan_b_in(chan_b),
    .sample_valid_in(sv), .iq_out(iq), .i_valid_out(i_valid), .q_valid_out(q_valid),
    .stage_enable_out(stg), .mixer_type_select_out(mix), .gain_select_out(gain),
    .if_mode_out(ifm));

  // handshakes sampled at the falling edge, where the rising-edge values have settled
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic [1:0] er);
    logic aw_t, w_t, b_t;
    b_t = 1'b0;
    @(posedge clk);
    awaddr <= a;
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!b_t) begin
      @(negedge clk);
      aw_t = awvalid & awready;
      w_t = wvalid & wready;
      b_t = bvalid;
      if (b_t) `CHK(bresp, er)
      @(posedge clk);
      if (aw_t) awvalid <= 1'b0;
      if (w_t) wvalid <= 1'b0;
      if (b_t) bready <= 1'b0;
    end
  endtask

  task automatic rd(input logic [15:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic ar_t, r_t;
    r_t = 1'b0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!r_t) begin
      @(negedge clk);
      ar_t = arvalid & arready;
      r_t = rvalid;
      if (r_t) begin
        `CHK(rdata, ed)
        `CHK(rresp, er)
      end
      @(posedge clk);
      if (ar_t) arvalid <= 1'b0;
      if (r_t) rready <= 1'b0;
    end
  endtask

  // first interval may straddle a ratio change, so only the second counts
  task automatic per(input logic cplx, output int n);
    for (int j = 0; j < 2; j++) begin
      n = 0;
      do begin
        @(negedge clk);
        n++;
      end while (i_valid !== 1'b1 && n < 200);
    end
    `CHK(q_valid, cplx)
  endtask

  task give_verdict;
    $display("comparisons=%0d err_count=%0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    #500000;
    err_count++;
    give_verdict;
  end

  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    run <= 1'b1;
    rd(ctrl_addr, 32'h00000000, 2'h0);
    rd(insel_addr, 32'h00000000, 2'h0);
    `CHK(stg, 6'h03)
    wr(16'h0d48, 8'hff, 2'h2);
    rd(16'h0d48, 32'h00000000, 2'h2);
    wr(insel_addr, 8'hfb, 2'h0);
    rd(insel_addr, 32'h000000f1, 2'h0);
    wr(ctrl_addr, 8'he3, 2'h0);
    rd(ctrl_addr, 32'h000000e3, 2'h0);
    `CHK({mix, gain, ifm}, 4'he)
    for (int k = 0; k < 12; k++) begin
      for (int c = 0; c < 2; c++) begin
        wr(insel_addr, {tbl[k][19:16], 4'h0}, 2'h0);
        wr(ctrl_addr, {4'h0, c[0], tbl[k][22:20]}, 2'h0);
        `CHK(stg, tbl[k][13:8])
        per(!c[0], p);
        `CHK(p, c[0] ? int'(tbl[k][7:0]) / 2 : int'(tbl[k][7:0]))
      end
    end
    // slow converter: only every other cycle carries a sample
    wr(insel_addr, 8'h04, 2'h0);
    wr(ctrl_addr, 8'h83, 2'h0);
    slow <= 1'b1;
    per(1'b1, p);
    `CHK(p, 4)
    `CHK(iq.q, iq.i + 16'h1000)
    slow <= 1'b0;
    wr(insel_addr, 8'h01, 2'h0);
    per(1'b1, p);
    `CHK(iq.i, iq.q + 16'h1000)
    wr(insel_addr, 8'h00, 2'h0);
    wr(ctrl_addr, 8'h0b, 2'h0);
    // mix phase starts at zero after complex outputs; channel a steps by one per sample
    for (int m = 0; m < 4; m++) begin
      @(negedge clk);
      `CHK(iq.i, (m == 1 || m == 2) ? 16'h0001 - chan_a : chan_a - 16'h0001)
    end
    per(1'b0, p);
    `CHK(p, 1)
    `CHK(iq.q, 16'h0000)
    give_verdict;
  end
endmodule
